// ---- torque_pos_pkg.sv ----
// Constants, encodings and register map for the torque limit and position table block.
`default_nettype none
package torque_pos_pkg;

  // ==========================================================================
  // Widths
  localparam int TQ_W = 16;
  localparam int AUX_W = 12;
  localparam int AUX_FS_SHIFT = 11;
  localparam int GAIN_W = 14;
  localparam int PCT_W = 9;
  localparam int FREQ_W = 10;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int POS_W = 32;
  localparam int SEC_AW = 5;

  // ==========================================================================
  // Register map (word addresses on the plain register port)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LIM_POS = 8'h01;
  localparam logic [7:0] REG_LIM_NEG = 8'h02;
  localparam logic [7:0] REG_LIM_FREGEN = 8'h03;
  localparam logic [7:0] REG_LIM_RREGEN = 8'h04;
  localparam logic [7:0] REG_AUX_GAIN = 8'h05;
  localparam logic [7:0] REG_AUX_BIAS = 8'h06;
  localparam logic [7:0] REG_POS_MAX_FREQ = 8'h07;
  localparam logic [7:0] REG_ENC_PPR = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h09;
  localparam logic [7:0] REG_TORQUE = 8'h0A;
  localparam logic [7:0] REG_TARGET_LO = 8'h0B;
  localparam logic [7:0] REG_TARGET_HI = 8'h0C;
  localparam logic [2:0] SEC_BASE_TOP = 3'h2;

  // ==========================================================================
  // Reset values
  localparam logic [4:0] RST_AUX_FUNC = 5'h00;
  localparam logic [8:0] RST_LIM_PCT = 9'h0C8;
  localparam logic [13:0] RST_AUX_GAIN = 14'h03E8;
  localparam logic [9:0] RST_POS_MAX_FREQ = 10'h064;
  localparam logic [15:0] RST_ENC_PPR = 16'h0400;

  // ==========================================================================
  // Aux analog input function codes
  localparam logic [4:0] FN_LIM_POS = 5'h0B;
  localparam logic [4:0] FN_LIM_NEG = 5'h0C;
  localparam logic [4:0] FN_LIM_REGEN = 5'h0D;
  localparam logic [4:0] FN_LIM_BOTH = 5'h0E;
  localparam logic [4:0] FN_TCOMP = 5'h10;

  // ==========================================================================
  // Ranges; torque is in 0.1 percent, frequency in 0.1 Hz
  localparam logic [8:0] LIM_MAX_PCT = 9'h12C;
  localparam logic [3:0] PCT_TO_TQ = 4'hA;
  localparam logic [15:0] SEC_MAX = 16'h270F;
  localparam logic [9:0] FREQ_MIN = 10'h001;
  localparam logic [9:0] FREQ_MAX = 10'h3E8;

  // Quadrant index doubles as the index of its fixed limit.
  typedef enum logic [1:0] {Q1_FWD_MOTOR, Q3_REV_MOTOR, Q2_REV_REGEN, Q4_FWD_REGEN} quad_e;
  typedef enum logic {SEQ_ROT, SEQ_PULSE} seq_e;

endpackage
`default_nettype wire

// ---- section_mem.sv ----
// Section table storage: one write port, one read port with registered read data.
`default_nettype none
module section_mem #(
  parameter int AW = 5,
  parameter int DW = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic re_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [(1<<AW)];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // A read in the same cycle as a write to the same word returns the old value.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else if (re_i) begin
      rdata_o <= mem[raddr_i];
    end
  end
endmodule
`default_nettype wire

// ---- torque_limit_and_position_table.sv ----
// Torque compensation, quadrant torque clamp and position section table.
`default_nettype none
module torque_limit_and_position_table (
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [15:0] RDATA_O,
  input wire logic signed [15:0] TORQUE_REF_I,
  input wire logic signed [15:0] SPEED_I,
  input wire logic signed [11:0] AUX_ANALOG_INPUT_I,
  input wire logic [9:0] FREQ_REQ_I,
  input wire logic [3:0] POSITION_SECTION_SELECT_I,
  output logic signed [15:0] TORQUE_CMD_O,
  output logic [1:0] QUADRANT_O,
  output logic TORQUE_LIMITING_O,
  output logic [9:0] POS_FREQ_O,
  output logic signed [31:0] POS_TARGET_O,
  output logic POS_DIR_REV_O,
  output logic POS_TARGET_VALID_O
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [4:0] aux_func;
    logic [3:0][8:0] lim;
    logic [13:0] gain;
    logic signed [15:0] bias;
    logic [9:0] max_freq;
    logic [15:0] ppr;
    logic signed [15:0] torque;
    logic [1:0] quad;
    logic limiting;
    logic [9:0] freq;
    logic [15:0] rdata;
    logic rd_mem;
    torque_pos_pkg::seq_e phase;
    logic pend;
    torque_pos_pkg::seq_e pend_phase;
    logic [3:0] pend_sec;
    logic signed [15:0] rot_hold;
    logic [3:0] rot_sec;
    logic rot_ok;
    logic signed [31:0] target;
    logic [3:0] tgt_sec;
    logic target_valid;
  } state_s;

  localparam state_s RST_STATE = '{
    aux_func: torque_pos_pkg::RST_AUX_FUNC,
    lim: {4{torque_pos_pkg::RST_LIM_PCT}},
    gain: torque_pos_pkg::RST_AUX_GAIN,
    max_freq: torque_pos_pkg::RST_POS_MAX_FREQ,
    ppr: torque_pos_pkg::RST_ENC_PPR,
    phase: torque_pos_pkg::SEQ_ROT,
    pend_phase: torque_pos_pkg::SEQ_ROT,
    default: '0
  };

  state_s st_reg;
  state_s st_next;

  // ==========================================================================
  // Helpers
  function automatic logic signed [31:0] clamp(input logic signed [31:0] v,
                                               input logic signed [31:0] lo,
                                               input logic signed [31:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic is_sec(input logic [7:0] a);
    is_sec = (a[7:5] == torque_pos_pkg::SEC_BASE_TOP);
  endfunction

  // ==========================================================================
  // Section memory
  logic mem_we;
  logic mem_re;
  logic [4:0] mem_raddr;
  logic [15:0] mem_wdata;
  logic [15:0] mem_rdata;

  section_mem #(
    .AW(torque_pos_pkg::SEC_AW),
    .DW(torque_pos_pkg::DATA_W)
  ) section_mem_i (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RST_N_I),
    .we_i(mem_we),
    .waddr_i(ADDR_I[4:0]),
    .wdata_i(mem_wdata),
    .re_i(mem_re),
    .raddr_i(mem_raddr),
    .rdata_o(mem_rdata)
  );

  // ==========================================================================
  // Torque path
  logic signed [26:0] aux_prod;
  logic signed [31:0] aux_pct;
  logic signed [15:0] comp;
  logic signed [15:0] aux_lim;
  logic signed [15:0] tq_sum;
  torque_pos_pkg::quad_e quad;
  logic aux_sel;
  logic signed [15:0] lim_eff;
  logic signed [15:0] tq_clamped;

  always_comb begin
    // Full scale of the signed aux input is 2^11, so gain 100.0 % gives 100.0 % torque.
    aux_prod = AUX_ANALOG_INPUT_I * $signed({1'b0, st_reg.gain});
    aux_pct = clamp(32'(aux_prod >>> torque_pos_pkg::AUX_FS_SHIFT) + 32'(st_reg.bias),
                    -32'sd32767, 32'sd32767);
    // Polarity is kept: the run direction never enters this term.
    comp = (st_reg.aux_func == torque_pos_pkg::FN_TCOMP) ? 16'(aux_pct) : 16'h0000;
    aux_lim = 16'(clamp(aux_pct, 32'sd0, 32'sd32767));
    // Compensation is added before the clamp, so the clamp wins over it.
    tq_sum = 16'(clamp(32'(TORQUE_REF_I) + 32'(comp), -32'sd32767, 32'sd32767));
    case ({SPEED_I[15], tq_sum[15]})
      2'b00: quad = torque_pos_pkg::Q1_FWD_MOTOR;
      2'b11: quad = torque_pos_pkg::Q3_REV_MOTOR;
      2'b10: quad = torque_pos_pkg::Q2_REV_REGEN;
      default: quad = torque_pos_pkg::Q4_FWD_REGEN;
    endcase
    case (st_reg.aux_func)
      torque_pos_pkg::FN_LIM_POS: aux_sel = (quad == torque_pos_pkg::Q1_FWD_MOTOR);
      torque_pos_pkg::FN_LIM_NEG: aux_sel = (quad == torque_pos_pkg::Q3_REV_MOTOR) ||
                                            (quad == torque_pos_pkg::Q4_FWD_REGEN);
      torque_pos_pkg::FN_LIM_REGEN: aux_sel = (quad == torque_pos_pkg::Q2_REV_REGEN) ||
                                              (quad == torque_pos_pkg::Q4_FWD_REGEN);
      torque_pos_pkg::FN_LIM_BOTH: aux_sel = 1'b1;
      default: aux_sel = 1'b0;
    endcase
    lim_eff = aux_sel ? aux_lim
                      : 16'(st_reg.lim[quad] * torque_pos_pkg::PCT_TO_TQ);
    tq_clamped = 16'(clamp(32'(tq_sum), -32'(lim_eff), 32'(lim_eff)));
  end

  // ==========================================================================
  // Registers, bus and section sequencer
  always_comb begin
    st_next = st_reg;
    mem_we = 1'b0;
    mem_re = 1'b0;
    mem_raddr = '0;
    mem_wdata = 16'(clamp(32'($signed(WDATA_I)), -32'(torque_pos_pkg::SEC_MAX),
                          32'(torque_pos_pkg::SEC_MAX)));
    st_next.torque = tq_clamped;
    st_next.quad = quad;
    st_next.limiting = (tq_clamped != tq_sum);
    st_next.freq = (FREQ_REQ_I > st_reg.max_freq) ? st_reg.max_freq : FREQ_REQ_I;

    if (WR_I) begin
      if (is_sec(ADDR_I)) begin
        mem_we = 1'b1;
      end
      case (ADDR_I)
        torque_pos_pkg::REG_CTRL: st_next.aux_func = WDATA_I[4:0];
        torque_pos_pkg::REG_LIM_POS, torque_pos_pkg::REG_LIM_NEG,
        torque_pos_pkg::REG_LIM_FREGEN, torque_pos_pkg::REG_LIM_RREGEN: begin
          st_next.lim[ADDR_I[1:0] - 2'h1] = 9'(clamp(32'(WDATA_I), 32'sd0,
                                                      32'(torque_pos_pkg::LIM_MAX_PCT)));
        end
        torque_pos_pkg::REG_AUX_GAIN: st_next.gain = WDATA_I[13:0];
        torque_pos_pkg::REG_AUX_BIAS: st_next.bias = WDATA_I;
        torque_pos_pkg::REG_POS_MAX_FREQ: begin
          st_next.max_freq = 10'(clamp(32'(WDATA_I), 32'(torque_pos_pkg::FREQ_MIN),
                                       32'(torque_pos_pkg::FREQ_MAX)));
        end
        torque_pos_pkg::REG_ENC_PPR: st_next.ppr = WDATA_I;
        default: ;
      endcase
    end

    st_next.rd_mem = 1'b0;
    st_next.rdata = '0;
    if (RD_I) begin
      case (ADDR_I)
        torque_pos_pkg::REG_CTRL: st_next.rdata = {11'h000, st_reg.aux_func};
        torque_pos_pkg::REG_LIM_POS, torque_pos_pkg::REG_LIM_NEG,
        torque_pos_pkg::REG_LIM_FREGEN, torque_pos_pkg::REG_LIM_RREGEN: begin
          st_next.rdata = {7'h00, st_reg.lim[ADDR_I[1:0] - 2'h1]};
        end
        torque_pos_pkg::REG_AUX_GAIN: st_next.rdata = {2'h0, st_reg.gain};
        torque_pos_pkg::REG_AUX_BIAS: st_next.rdata = st_reg.bias;
        torque_pos_pkg::REG_POS_MAX_FREQ: st_next.rdata = {6'h00, st_reg.max_freq};
        torque_pos_pkg::REG_ENC_PPR: st_next.rdata = st_reg.ppr;
        torque_pos_pkg::REG_STATUS: begin
          st_next.rdata = {8'h00, st_reg.quad, st_reg.limiting, st_reg.target_valid,
                           st_reg.tgt_sec};
        end
        torque_pos_pkg::REG_TORQUE: st_next.rdata = st_reg.torque;
        torque_pos_pkg::REG_TARGET_LO: st_next.rdata = st_reg.target[15:0];
        torque_pos_pkg::REG_TARGET_HI: st_next.rdata = st_reg.target[31:16];
        default: st_next.rd_mem = is_sec(ADDR_I);
      endcase
    end

    // Bus reads of the table borrow the read port; the sequencer just skips a turn.
    st_next.pend = 1'b0;
    if (RD_I && is_sec(ADDR_I)) begin
      mem_re = 1'b1;
      mem_raddr = ADDR_I[4:0];
    end else begin
      mem_re = 1'b1;
      mem_raddr = {POSITION_SECTION_SELECT_I, st_reg.phase};
      st_next.pend = 1'b1;
      st_next.pend_phase = st_reg.phase;
      st_next.pend_sec = POSITION_SECTION_SELECT_I;
      case (st_reg.phase)
        torque_pos_pkg::SEQ_ROT: st_next.phase = torque_pos_pkg::SEQ_PULSE;
        torque_pos_pkg::SEQ_PULSE: st_next.phase = torque_pos_pkg::SEQ_ROT;
        default: st_next.phase = torque_pos_pkg::SEQ_ROT;
      endcase
    end

    // A pulse count only pairs with a rotation count of the same section.
    if (st_reg.pend) begin
      case (st_reg.pend_phase)
        torque_pos_pkg::SEQ_ROT: begin
          st_next.rot_hold = mem_rdata;
          st_next.rot_sec = st_reg.pend_sec;
          st_next.rot_ok = 1'b1;
        end
        torque_pos_pkg::SEQ_PULSE: begin
          if (st_reg.rot_ok && (st_reg.rot_sec == st_reg.pend_sec)) begin
            st_next.target = 32'(st_reg.rot_hold * $signed({1'b0, st_reg.ppr}))
                             + 32'($signed(mem_rdata));
            st_next.tgt_sec = st_reg.pend_sec;
            st_next.target_valid = 1'b1;
          end
        end
        default: st_next.rot_ok = 1'b0;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_reg <= RST_STATE;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign RDATA_O = st_reg.rd_mem ? mem_rdata : st_reg.rdata;
  assign TORQUE_CMD_O = st_reg.torque;
  assign QUADRANT_O = st_reg.quad;
  assign TORQUE_LIMITING_O = st_reg.limiting;
  assign POS_FREQ_O = st_reg.freq;
  assign POS_TARGET_O = st_reg.target;
  assign POS_DIR_REV_O = st_reg.target[31];
  // Valid only while the selected section is the one the target was built from.
  assign POS_TARGET_VALID_O = st_reg.target_valid &&
                              (st_reg.tgt_sec == POSITION_SECTION_SELECT_I);

  // ==========================================================================
  // Assertions
  property p_comp_only_fn16;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      (st_reg.aux_func != torque_pos_pkg::FN_TCOMP) |-> (comp == 16'h0000);
  endproperty
  a_comp_only_fn16: assert property (p_comp_only_fn16)
    else $error("compensation present without function 16");
  property p_comp_sign;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      (st_reg.aux_func == torque_pos_pkg::FN_TCOMP && st_reg.bias == 16'sh0000 &&
       st_reg.gain != 14'h0000 && AUX_ANALOG_INPUT_I < 0) |-> (comp < 0);
  endproperty
  a_comp_sign: assert property (p_comp_sign)
    else $error("compensation sign does not follow negative analog input");
  property p_comp_pos;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      (st_reg.aux_func == torque_pos_pkg::FN_TCOMP && st_reg.bias >= 0 &&
       AUX_ANALOG_INPUT_I >= 0) |-> (comp >= 0) && (tq_sum >= TORQUE_REF_I);
  endproperty
  a_comp_pos: assert property (p_comp_pos)
    else $error("positive analog level did not give positive compensation");
  property p_lim_range;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      WR_I && ADDR_I == torque_pos_pkg::REG_LIM_POS |=>
        (st_reg.lim[0] <= torque_pos_pkg::LIM_MAX_PCT);
  endproperty
  a_lim_range: assert property (p_lim_range)
    else $error("torque limit stored above 300 percent");
  property p_quad_fixed;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      (st_reg.aux_func == 5'h00 && !SPEED_I[15] && tq_sum[15]) |->
        (lim_eff == 16'(st_reg.lim[3] * 4'hA));
  endproperty
  a_quad_fixed: assert property (p_quad_fixed)
    else $error("forward regeneration did not use the reverse regenerating limit");
  property p_fn12;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      (st_reg.aux_func == torque_pos_pkg::FN_LIM_NEG && tq_sum[15]) |-> (lim_eff == aux_lim);
  endproperty
  a_fn12: assert property (p_fn12)
    else $error("code 12 limit missing in quadrant three or four");
  property p_fn13;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      (st_reg.aux_func == torque_pos_pkg::FN_LIM_REGEN && (SPEED_I[15] != tq_sum[15]))
        |-> (lim_eff == aux_lim);
  endproperty
  a_fn13: assert property (p_fn13)
    else $error("code 13 limit missing in a regenerating quadrant");
  property p_fn14;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      (st_reg.aux_func == torque_pos_pkg::FN_LIM_BOTH) |-> (lim_eff == aux_lim);
  endproperty
  a_fn14: assert property (p_fn14)
    else $error("code 14 limit not applied");
  property p_clamp;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      1'b1 |=> (TORQUE_CMD_O <= $past(lim_eff)) && (TORQUE_CMD_O >= -$past(lim_eff)) &&
               (TORQUE_LIMITING_O == (TORQUE_CMD_O != $past(tq_sum)));
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("torque command outside selected limit");
  property p_freq_cap;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      1'b1 |=> (POS_FREQ_O <= $past(st_reg.max_freq)) &&
               (POS_FREQ_O == $past(FREQ_REQ_I) || POS_FREQ_O == $past(st_reg.max_freq));
  endproperty
  a_freq_cap: assert property (p_freq_cap)
    else $error("positioning frequency above its cap");
  property p_sec_range;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      mem_we |-> ($signed(mem_wdata) <= 16'sh270F) && ($signed(mem_wdata) >= -16'sh270F);
  endproperty
  a_sec_range: assert property (p_sec_range)
    else $error("section value stored outside plus or minus 9999");
endmodule
`default_nettype wire

// ---- motor_side_model.sv ----
// Behavioural model of the speed regulator and encoder feeding the torque clamp.
`default_nettype none
module motor_side_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic signed [15:0] torque_set_i,
  input wire logic signed [15:0] speed_set_i,
  output logic signed [15:0] torque_ref_o,
  output logic signed [15:0] speed_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================
  // Outputs move one edge after a new request, as a sampled regulator would.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      torque_ref_o <= '0;
      speed_o <= '0;
    end else begin
      torque_ref_o <= torque_set_i;
      speed_o <= speed_set_i;
    end
  end
endmodule
`default_nettype wire

// ---- torque_limit_and_position_table_bench.sv ----
// Self-checking bench for the torque clamp and position section table.
`default_nettype none
module torque_limit_and_position_table_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000, rdata, d;
  logic signed [15:0] tq_set = '0, sp_set = '0, tq_ref, speed, cmd;
  logic signed [11:0] aux = '0;
  logic [9:0] freq = '0, pos_freq;
  logic [3:0] sel = '0;
  logic [1:0] quad;
  logic limiting, dir_rev, valid;
  logic signed [31:0] target;
  int failures = 0, tests_run = 0, sg;
  logic [3:0] mask [11:14] = '{4'h1, 4'hA, 4'hC, 4'hF};
  always #2.5 clk = ~clk;
  motor_side_model motor_side_model_i (.clk_i(clk), .rst_n_i(rst_n), .torque_set_i(tq_set),
    .speed_set_i(sp_set), .torque_ref_o(tq_ref), .speed_o(speed));
  torque_limit_and_position_table torque_limit_and_position_table_i (.CORE_CLK_I(clk),
    .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .TORQUE_REF_I(tq_ref), .SPEED_I(speed), .AUX_ANALOG_INPUT_I(aux), .FREQ_REQ_I(freq),
    .POSITION_SECTION_SELECT_I(sel), .TORQUE_CMD_O(cmd), .QUADRANT_O(quad),
    .TORQUE_LIMITING_O(limiting), .POS_FREQ_O(pos_freq), .POS_TARGET_O(target),
    .POS_DIR_REV_O(dir_rev), .POS_TARGET_VALID_O(valid));
  // ==========================================
  // Bus and comparison tasks.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // Partner takes one edge and the clamp one more, so three edges leave margin.
  task automatic motor(input int t, input int s);
    @(posedge clk);
    tq_set <= 16'(t);
    sp_set <= 16'(s);
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic quad_run(input int q, input int mag);
    sg = (q == 0 || q == 2) ? 1 : -1;
    motor(sg * mag, (q == 0 || q == 3) ? 100 : -100);
  endtask
  // One edge first, so a select just driven has reached the design before valid is looked at.
  task automatic wait_target();
    @(posedge clk);
    #1;
    for (int i = 0; i < 12 && valid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic results();
    if (failures == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    results();
  end
  // ==========================================
  // Test sequence.
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(8'h01, d);
    chk(d, 32'(torque_pos_pkg::RST_LIM_PCT));
    rd_reg(8'h05, d);
    chk(d, 32'(torque_pos_pkg::RST_AUX_GAIN));
    rd_reg(8'h07, d);
    chk(d, 32'(torque_pos_pkg::RST_POS_MAX_FREQ));
    rd_reg(8'h20, d);
    chk(d, 32'h0);
    wr_reg(8'h01, 16'h0190);
    rd_reg(8'h01, d);
    chk(d, 32'(torque_pos_pkg::LIM_MAX_PCT));
    // Distinct limits per quadrant expose any swapped mapping.
    for (int q = 0; q < 4; q++) wr_reg(8'(q + 1), 16'((q + 2) * 10));
    for (int q = 0; q < 4; q++) begin
      quad_run(q, 2000);
      chk(cmd, 32'(sg * (q + 2) * 100));
      chk(quad, 32'(q));
      chk(limiting, 32'h1);
    end
    motor(100, 100);
    chk(cmd, 32'd100);
    chk(limiting, 32'h0);
    for (int q = 0; q < 4; q++) wr_reg(8'(q + 1), 16'd300);
    wr_reg(8'h00, 16'(torque_pos_pkg::FN_TCOMP));
    aux <= 12'sd1024;
    motor(0, -100);
    chk(cmd, 32'd500);
    @(posedge clk);
    aux <= -12'sd1024;
    motor(0, 100);
    chk(cmd, -32'sd500);
    // Bias is added to the scaled input before it becomes compensation.
    wr_reg(8'h06, 16'd100);
    motor(0, 100);
    chk(cmd, -32'sd400);
    wr_reg(8'h06, 16'h0000);
    wr_reg(8'h01, 16'd20);
    aux <= 12'sd1024;
    motor(300, 100);
    chk(cmd, 32'd200);
    wr_reg(8'h01, 16'd300);
    for (int c = 11; c <= 14; c++) begin
      wr_reg(8'h00, 16'(c));
      for (int q = 0; q < 4; q++) begin
        quad_run(q, 2000);
        chk(cmd, 32'(sg * (mask[c][q] ? 500 : 2000)));
      end
    end
    wr_reg(8'h05, 16'd2000);
    motor(3000, 100);
    chk(cmd, 32'd1000);
    wr_reg(8'h07, 16'd50);
    freq <= 10'd80;
    motor(0, 0);
    chk(pos_freq, 32'd50);
    @(posedge clk);
    freq <= 10'd30;
    motor(0, 0);
    chk(pos_freq, 32'd30);
    wr_reg(8'h07, 16'h0000);
    rd_reg(8'h07, d);
    chk(d, 32'(torque_pos_pkg::FREQ_MIN));
    for (int s = 0; s < 32; s++) wr_reg(8'(8'h40 + s), 16'h0000);
    wr_reg(8'h40, 16'd12000);
    rd_reg(8'h40, d);
    chk(d, 32'(torque_pos_pkg::SEC_MAX));
    wr_reg(8'h46, 16'd2);
    wr_reg(8'h47, -16'sd5);
    wr_reg(8'h5E, -16'sd1);
    wr_reg(8'h5F, -16'sd768);
    sel <= 4'h3;
    wait_target();
    chk(target, 32'sd2043);
    chk(valid, 32'h1);
    chk(dir_rev, 32'h0);
    @(posedge clk);
    sel <= 4'hF;
    #1 chk(valid, 32'h0);
    wait_target();
    chk(target, -32'sd1792);
    chk(dir_rev, 32'h1);
    // A new pulses-per-revolution setting reaches the target within a few cycles.
    wr_reg(8'h08, 16'd2000);
    repeat (6) @(posedge clk);
    #1 chk(target, -32'sd2768);
    rd_reg(8'h0B, d);
    chk(d, 32'h0000F530);
    rd_reg(8'h0C, d);
    chk(d, 32'h0000FFFF);
    results();
  end
endmodule
`default_nettype wire
